//--- inc/bbs_defines.svh
// constants for the branch and bit-set execution slice
// assumes inclusion by bare name from each design file
`ifndef BBS_DEFINES_SVH
`define BBS_DEFINES_SVH

// ************************************************
// instruction encodings
// ************************************************
`define BBS_OPC_NEG        8'he6
`define BBS_OPC_NOCARRY    8'he3
`define BBS_OPC_NOTNEG     8'he7
`define BBS_OPC_NOOVF      8'he5
`define BBS_OPC_NOTZERO    8'he1
`define BBS_OPC_ALWAYS     5'h1a
`define BBS_OPC_SETBIT     4'h8

// ************************************************
// field positions
// ************************************************
`define BBS_F_OPC8_HI      15
`define BBS_F_OPC8_LO      8
`define BBS_F_OPC5_LO      11
`define BBS_F_OPC4_LO      12
`define BBS_F_SHORT_HI     7
`define BBS_F_LONG_HI      10
`define BBS_F_BIT_HI       11
`define BBS_F_BIT_LO       9
`define BBS_F_ACCESS       8
`define BBS_F_REG_HI       7

// ************************************************
// widths, steps and addressing limits
// ************************************************
`define BBS_PC_W           21
`define BBS_DADDR_W        12
`define BBS_PC_STEP        21'h000002
`define BBS_PC_RST         21'h000000
`define BBS_INDEXED_MAX    8'h5f
`define BBS_ACCESS_SPLIT   8'h60
`define BBS_ACCESS_HI_PAGE 4'hf
`define BBS_LOW_PAGE       4'h0

// ************************************************
// register map
// ************************************************
`define BBS_REG_CTRL       8'h00
`define BBS_REG_BANK       8'h04
`define BBS_REG_STATUS     8'h08
`define BBS_REG_PC         8'h0c
`define BBS_CTRL_EXT_BIT   0
`define BBS_BANK_HI        3
`define BBS_CTRL_RST       1'h0
`define BBS_BANK_RST       4'h0
`define BBS_CNT_RST        8'h00
`define BBS_ZERO32         32'h00000000

`endif

//--- inc/bbs_pkg.sv
// types shared by the branch and bit-set execution slice
// assumes nothing of its surroundings
`default_nettype none
package bbs_pkg;
  // quarter phases, gray along q1-q2-q3-q4
  typedef enum logic [1:0] {
    BBS_Q1 = 2'b00,
    BBS_Q2 = 2'b01,
    BBS_Q3 = 2'b11,
    BBS_Q4 = 2'b10
  } bbs_phase_e;

  // instruction classes handled here
  typedef enum logic [1:0] {
    BBS_OP_NOP   = 2'b00,
    BBS_OP_BCOND = 2'b01,
    BBS_OP_BRA   = 2'b11,
    BBS_OP_BSF   = 2'b10
  } bbs_op_e;
endpackage
`default_nettype wire

//--- rtl/bbs_addr_gen.sv
// data memory address former for the bit-set operation
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "bbs_defines.svh"

module bbs_addr_gen (
  input  wire logic [7:0]               reg_in,        // register field of the instruction
  input  wire logic                     access_sel_in, // bank-access bit
  input  wire logic [`BBS_BANK_HI:0]    bank_in,       // bank select value
  input  wire logic                     ext_en_in,     // extended set enabled
  input  wire logic [`BBS_DADDR_W-1:0]  index_base_in, // base for indexed offset mode
  output logic      [`BBS_DADDR_W-1:0]  addr_out       // formed data address
);

  // ************************************************
  // address selection
  // ************************************************
  // one adder only: the indexed path is the sole arithmetic one
  always_comb begin
    addr_out = {`BBS_LOW_PAGE, reg_in};
    if (access_sel_in) begin
      addr_out = {bank_in, reg_in};
    end else if (ext_en_in && (reg_in <= `BBS_INDEXED_MAX)) begin
      addr_out = index_base_in + {`BBS_LOW_PAGE, reg_in};
    end else if (reg_in >= `BBS_ACCESS_SPLIT) begin
      addr_out = {`BBS_ACCESS_HI_PAGE, reg_in};
    end
  end

endmodule
`default_nettype wire

//--- rtl/bbs_exec.sv
// branch and bit-set execution slice with quarter-phase sequencer and apb control
// assumes flags, instruction and data memory are on clk_in; read data one cycle after strobe
`timescale 1ns/1ps
`default_nettype none
`include "bbs_defines.svh"

module bbs_exec (
  input  wire logic                     clk_in,           // core clock 100 mhz
  input  wire logic                     rst_in,           // synchronous reset, high
  input  wire logic                     psel_in,          // apb select
  input  wire logic                     penable_in,       // apb enable
  input  wire logic                     pwrite_in,        // apb direction
  input  wire logic [7:0]               paddr_in,         // apb byte address
  input  wire logic [31:0]              pwdata_in,        // apb write data
  output logic      [31:0]              prdata_out,       // apb read data
  output logic                          pready_out,       // apb ready
  output logic                          pslverr_out,      // apb error, unmapped
  input  wire logic [15:0]              instr_in,         // fetched instruction word
  input  wire logic                     instr_valid_in,   // instruction word present
  input  wire logic                     neg_flag_in,      // negative flag
  input  wire logic                     carry_flag_in,    // carry flag
  input  wire logic                     ovf_flag_in,      // overflow flag
  input  wire logic                     zero_flag_in,     // zero flag
  input  wire logic [`BBS_DADDR_W-1:0]  index_base_in,    // indexed mode base pointer
  input  wire logic [7:0]               mem_rdata_in,     // data memory read data
  output logic      [`BBS_PC_W-1:0]     pc_out,           // program counter
  output logic                          fetch_req_out,    // waiting for an instruction
  output logic      [`BBS_DADDR_W-1:0]  mem_addr_out,     // data memory address
  output logic                          mem_rd_out,       // data memory read strobe
  output logic                          mem_wr_out,       // data memory write strobe
  output logic      [7:0]               mem_wdata_out,    // data memory write data
  output logic                          branch_taken_out, // branch taken this cycle
  output logic                          flush_out,        // flushed nop cycle running
  output logic      [1:0]               phase_out,        // current quarter phase
  output logic                          instr_done_out    // instruction retired pulse
);

  // ************************************************
  // decode helpers
  // ************************************************
  // instruction class from a raw word
  function automatic bbs_pkg::bbs_op_e decode_op(input logic [15:0] w);
    logic [7:0] o8;
    o8 = w[`BBS_F_OPC8_HI:`BBS_F_OPC8_LO];
    decode_op = bbs_pkg::BBS_OP_NOP;
    if (o8 == `BBS_OPC_NEG)     decode_op = bbs_pkg::BBS_OP_BCOND;
    if (o8 == `BBS_OPC_NOCARRY) decode_op = bbs_pkg::BBS_OP_BCOND;
    if (o8 == `BBS_OPC_NOTNEG)  decode_op = bbs_pkg::BBS_OP_BCOND;
    if (o8 == `BBS_OPC_NOOVF)   decode_op = bbs_pkg::BBS_OP_BCOND;
    if (o8 == `BBS_OPC_NOTZERO) decode_op = bbs_pkg::BBS_OP_BCOND;
    if (w[`BBS_F_OPC8_HI:`BBS_F_OPC5_LO] == `BBS_OPC_ALWAYS) decode_op = bbs_pkg::BBS_OP_BRA;
    if (w[`BBS_F_OPC8_HI:`BBS_F_OPC4_LO] == `BBS_OPC_SETBIT) decode_op = bbs_pkg::BBS_OP_BSF;
  endfunction

  // condition test for the conditional forms
  function automatic logic cond_met(input logic [7:0] o8, input logic n, input logic c,
                                    input logic v, input logic z);
    cond_met = 1'b0;
    case (o8)
      `BBS_OPC_NEG:     cond_met = n;
      `BBS_OPC_NOCARRY: cond_met = ~c;
      `BBS_OPC_NOTNEG:  cond_met = ~n;
      `BBS_OPC_NOOVF:   cond_met = ~v;
      `BBS_OPC_NOTZERO: cond_met = ~z;
      default:          cond_met = 1'b0;
    endcase
  endfunction

  // ************************************************
  // state
  // ************************************************
  bbs_pkg::bbs_phase_e         phase_q, phase_d;
  bbs_pkg::bbs_op_e            op_q, op_d;
  logic [15:0]                 ir_q, ir_d;
  logic [`BBS_PC_W-1:0]        pc_q, pc_d;
  logic [`BBS_PC_W-1:0]        off_q, off_d;
  logic [`BBS_PC_W-1:0]        target_q, target_d;
  logic                        taken_q, taken_d;
  logic                        flush_q, flush_d;
  logic                        fetch_q, fetch_d;
  logic                        done_q, done_d;
  logic [`BBS_DADDR_W-1:0]     maddr_q, maddr_d;
  logic                        mrd_q, mrd_d;
  logic                        mwr_q, mwr_d;
  logic [7:0]                  wdata_q, wdata_d;
  logic [7:0]                  tcnt_q, tcnt_d;
  logic                        ext_en_q, ext_en_d;
  logic [`BBS_BANK_HI:0]       bank_q, bank_d;
  logic [31:0]                 prdata_q, prdata_d;
  logic                        pready_q, pready_d;
  logic                        pslverr_q, pslverr_d;
  logic [`BBS_DADDR_W-1:0]     addr_w;
  logic [7:0]                  set_mask;

  // ************************************************
  // data address and bit mask
  // ************************************************
  // address is formed from the live word so it can be latched in q1
  bbs_addr_gen u_addr (
    .reg_in        (instr_in[`BBS_F_REG_HI:0]),
    .access_sel_in (instr_in[`BBS_F_ACCESS]),
    .bank_in       (bank_q),
    .ext_en_in     (ext_en_q),
    .index_base_in (index_base_in),
    .addr_out      (addr_w)
  );

  // one-hot mask from the bit index field
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      assign set_mask[gi] = (ir_q[`BBS_F_BIT_HI:`BBS_F_BIT_LO] == 3'(gi));
    end
  endgenerate

  // ************************************************
  // quarter-phase sequencer
  // ************************************************
  // no flag is written by this block, flags are inputs only
  always_comb begin
    phase_d  = phase_q;
    op_d     = op_q;
    ir_d     = ir_q;
    pc_d     = pc_q;
    off_d    = off_q;
    target_d = target_q;
    taken_d  = taken_q;
    flush_d  = flush_q;
    fetch_d  = 1'b0;
    done_d   = 1'b0;
    maddr_d  = maddr_q;
    mrd_d    = 1'b0;
    mwr_d    = 1'b0;
    wdata_d  = wdata_q;
    tcnt_d   = tcnt_q;
    case (phase_q)
      bbs_pkg::BBS_Q1: begin
        if (flush_q) begin
          phase_d = bbs_pkg::BBS_Q2;
        end else if (instr_valid_in) begin
          ir_d    = instr_in;
          op_d    = decode_op(instr_in);
          taken_d = 1'b0;
          pc_d    = pc_q + `BBS_PC_STEP;
          phase_d = bbs_pkg::BBS_Q2;
          if (decode_op(instr_in) == bbs_pkg::BBS_OP_BSF) begin
            maddr_d = addr_w;
            mrd_d   = 1'b1;
          end
        end else begin
          fetch_d = 1'b1;
        end
      end
      bbs_pkg::BBS_Q2: begin
        if (op_q == bbs_pkg::BBS_OP_BRA) begin
          off_d = {{(`BBS_PC_W-12){ir_q[`BBS_F_LONG_HI]}}, ir_q[`BBS_F_LONG_HI:0], 1'b0};
        end else begin
          off_d = {{(`BBS_PC_W-9){ir_q[`BBS_F_SHORT_HI]}}, ir_q[`BBS_F_SHORT_HI:0], 1'b0};
        end
        phase_d = bbs_pkg::BBS_Q3;
      end
      bbs_pkg::BBS_Q3: begin
        if (!flush_q) begin
          target_d = pc_q + off_q;
          if (op_q == bbs_pkg::BBS_OP_BRA) taken_d = 1'b1;
          if (op_q == bbs_pkg::BBS_OP_BCOND) begin
            taken_d = cond_met(ir_q[`BBS_F_OPC8_HI:`BBS_F_OPC8_LO], neg_flag_in, carry_flag_in,
                               ovf_flag_in, zero_flag_in);
          end
          if (op_q == bbs_pkg::BBS_OP_BSF) begin
            wdata_d = mem_rdata_in | set_mask;
            mwr_d   = 1'b1;
          end
        end
        phase_d = bbs_pkg::BBS_Q4;
      end
      bbs_pkg::BBS_Q4: begin
        phase_d = bbs_pkg::BBS_Q1;
        if (flush_q) begin
          // second cycle of a taken branch ends
          flush_d = 1'b0;
          done_d  = 1'b1;
          fetch_d = 1'b1;
        end else if (taken_q) begin
          // write pc in q4, then flush
          pc_d    = target_q;
          flush_d = 1'b1;
          tcnt_d  = tcnt_q + 8'h01;
        end else begin
          done_d  = 1'b1;
          fetch_d = 1'b1;
        end
        taken_d = 1'b0;
      end
      default: begin
        phase_d = bbs_pkg::BBS_Q1;
      end
    endcase
  end

  // register the sequencer state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_q  <= bbs_pkg::BBS_Q1;
      op_q     <= bbs_pkg::BBS_OP_NOP;
      ir_q     <= 16'h0000;
      pc_q     <= `BBS_PC_RST;
      off_q    <= `BBS_PC_RST;
      target_q <= `BBS_PC_RST;
      taken_q  <= 1'b0;
      flush_q  <= 1'b0;
      fetch_q  <= 1'b1;
      done_q   <= 1'b0;
      maddr_q  <= {`BBS_DADDR_W{1'b0}};
      mrd_q    <= 1'b0;
      mwr_q    <= 1'b0;
      wdata_q  <= 8'h00;
      tcnt_q   <= `BBS_CNT_RST;
    end else begin
      phase_q  <= phase_d;
      op_q     <= op_d;
      ir_q     <= ir_d;
      pc_q     <= pc_d;
      off_q    <= off_d;
      target_q <= target_d;
      taken_q  <= taken_d;
      flush_q  <= flush_d;
      fetch_q  <= fetch_d;
      done_q   <= done_d;
      maddr_q  <= maddr_d;
      mrd_q    <= mrd_d;
      mwr_q    <= mwr_d;
      wdata_q  <= wdata_d;
      tcnt_q   <= tcnt_d;
    end
  end

  // ************************************************
  // apb register slave
  // ************************************************
  // one wait state: ready is registered, writes land on the completing edge
  always_comb begin
    ext_en_d  = ext_en_q;
    bank_d    = bank_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = psel_in & penable_in & ~pready_q;
    if (pready_d) begin
      prdata_d  = `BBS_ZERO32;
      pslverr_d = 1'b0;
      case (paddr_in)
        `BBS_REG_CTRL:   prdata_d[`BBS_CTRL_EXT_BIT] = ext_en_q;
        `BBS_REG_BANK:   prdata_d[`BBS_BANK_HI:0] = bank_q;
        `BBS_REG_STATUS: prdata_d[15:0] = {tcnt_q, 2'b00, phase_q, flush_q, taken_q, fetch_q, done_q};
        `BBS_REG_PC:     prdata_d[`BBS_PC_W-1:0] = pc_q;
        default:         pslverr_d = 1'b1;
      endcase
    end
    if (psel_in && penable_in && pready_q && pwrite_in) begin
      if (paddr_in == `BBS_REG_CTRL) ext_en_d = pwdata_in[`BBS_CTRL_EXT_BIT];
      if (paddr_in == `BBS_REG_BANK) bank_d = pwdata_in[`BBS_BANK_HI:0];
    end
  end

  // register the bus state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_en_q  <= `BBS_CTRL_RST;
      bank_q    <= `BBS_BANK_RST;
      prdata_q  <= `BBS_ZERO32;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ext_en_q  <= ext_en_d;
      bank_q    <= bank_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign prdata_out       = prdata_q;
  assign pready_out       = pready_q;
  assign pslverr_out      = pslverr_q;
  assign pc_out           = pc_q;
  assign fetch_req_out    = fetch_q;
  assign mem_addr_out     = maddr_q;
  assign mem_rd_out       = mrd_q;
  assign mem_wr_out       = mwr_q;
  assign mem_wdata_out    = wdata_q;
  assign branch_taken_out = taken_q;
  assign flush_out        = flush_q;
  assign phase_out        = phase_q;
  assign instr_done_out   = done_q;

endmodule
`default_nettype wire

//--- verif/bbs_exec_monitor.sv
// assertion checker for the branch and bit-set execution slice
// assumes it is bound to bbs_exec and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "bbs_defines.svh"

module bbs_exec_monitor (
  input wire logic                 clk_in,           // core clock
  input wire logic                 rst_in,           // synchronous reset
  input wire logic [15:0]          instr_in,         // instruction word
  input wire logic                 instr_valid_in,   // word present
  input wire logic                 neg_flag_in,      // negative flag
  input wire logic                 carry_flag_in,    // carry flag
  input wire logic                 ovf_flag_in,      // overflow flag
  input wire logic                 zero_flag_in,     // zero flag
  input wire logic [7:0]           mem_rdata_in,     // data read
  input wire logic [`BBS_PC_W-1:0] pc_out,           // program counter
  input wire logic                 fetch_req_out,    // waiting for a word
  input wire logic [11:0]          mem_addr_out,     // data address
  input wire logic                 mem_rd_out,       // read strobe
  input wire logic                 mem_wr_out,       // write strobe
  input wire logic [7:0]           mem_wdata_out,    // write data
  input wire logic                 branch_taken_out, // taken in q4
  input wire logic                 flush_out,        // nop cycle
  input wire logic [1:0]           phase_out,        // quarter phase
  input wire logic                 instr_done_out,   // retire pulse
  input wire logic                 pready_out,       // apb ready
  input wire logic                 pslverr_out       // apb error
);
  logic [15:0]          ir_d;
  logic [15:0]          ir_q;
  logic [`BBS_PC_W-1:0] tgt_d;
  logic [`BBS_PC_W-1:0] tgt_q;
  logic                 acc;
  logic                 is_cond;
  logic                 want_now;
  logic [7:0]           mask_now;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ****************************************
  // helper state: accepted word and target
  // ****************************************
  assign acc = fetch_req_out && instr_valid_in && !flush_out && phase_out == bbs_pkg::BBS_Q1;
  assign is_cond = instr_in[15:8] inside {8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
  // target worked out at accept, since pc moves before the branch resolves
  always_comb begin
    ir_d = acc ? instr_in : ir_q;
    tgt_d = tgt_q;
    if (acc && instr_in[15:11] == `BBS_OPC_ALWAYS)
      tgt_d = pc_out + `BBS_PC_STEP + {{9{instr_in[10]}}, instr_in[10:0], 1'b0};
    else if (acc)
      tgt_d = pc_out + `BBS_PC_STEP + {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
    case (ir_q[15:8])
      `BBS_OPC_NEG:     want_now = neg_flag_in;
      `BBS_OPC_NOCARRY: want_now = !carry_flag_in;
      `BBS_OPC_NOTNEG:  want_now = !neg_flag_in;
      `BBS_OPC_NOOVF:   want_now = !ovf_flag_in;
      `BBS_OPC_NOTZERO: want_now = !zero_flag_in;
      default:          want_now = 1'b0;
    endcase
    mask_now = 8'h01 << ir_q[11:9];
  end
  always_ff @(posedge clk_in) begin
    ir_q  <= ir_d;
    tgt_q <= tgt_d;
  end

  cond_taken_a:
  assert property (acc && is_cond |-> ##3 branch_taken_out == $past(want_now))
    else $error("conditional branch decision wrong");
  always_taken_a:
  assert property (acc && instr_in[15:11] == `BBS_OPC_ALWAYS |-> ##3 branch_taken_out ##1 flush_out)
    else $error("unconditional branch not taken");
  target_pc_a:
  assert property ($rose(flush_out) |-> pc_out == tgt_q)
    else $error("branch target wrong");
  one_word_a:
  assert property (acc |=> pc_out == $past(pc_out) + `BBS_PC_STEP)
    else $error("pc did not step one word");
  flush_len_a:
  assert property (branch_taken_out |=> flush_out [*4] ##1 !flush_out)
    else $error("nop cycle length wrong");
  taken_q4_a:
  assert property (branch_taken_out |-> phase_out == bbs_pkg::BBS_Q4)
    else $error("pc write outside q4");
  done_after_a:
  assert property ($fell(flush_out) |-> instr_done_out)
    else $error("no retire after nop cycle");
  no_fetch_a:
  assert property (flush_out |-> !fetch_req_out)
    else $error("fetch during nop cycle");
  set_bit_a:
  assert property (acc && instr_in[15:12] == `BBS_OPC_SETBIT |-> ##1 mem_rd_out ##2
    (mem_wr_out && mem_wdata_out == ($past(mem_rdata_in) | mask_now)))
    else $error("bit set write wrong");
  access_hi_a:
  assert property (acc && instr_in[15:12] == `BBS_OPC_SETBIT && !instr_in[8] && instr_in[7:0] >= 8'h60
    |=> mem_addr_out == {`BBS_ACCESS_HI_PAGE, ir_q[7:0]})
    else $error("access bank high page wrong");

  cover property (branch_taken_out);
  cover property (mem_wr_out);
  cover property (pready_out && pslverr_out);
endmodule

bind bbs_exec bbs_exec_monitor u_mon (.clk_in, .rst_in, .instr_in, .instr_valid_in, .neg_flag_in,
  .carry_flag_in, .ovf_flag_in, .zero_flag_in, .mem_rdata_in, .pc_out, .fetch_req_out, .mem_addr_out,
  .mem_rd_out, .mem_wr_out, .mem_wdata_out, .branch_taken_out, .flush_out, .phase_out,
  .instr_done_out, .pready_out, .pslverr_out);
`default_nettype wire

//--- verif/bbs_mem_model.sv
// data memory and fetch port model facing the execution slice
// assumes strobes on clk_in; read data comes one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none

module bbs_mem_model (
  input  wire logic        clk_in,       // core clock
  input  wire logic [11:0] addr_in,      // data address
  input  wire logic        rd_in,        // read strobe
  input  wire logic        wr_in,        // write strobe
  input  wire logic [7:0]  wdata_in,     // write data
  output logic      [7:0]  rdata_out,    // read data
  input  wire logic        fetch_req_in, // core waits for a word
  input  wire logic        offer_in,     // bench has a word
  input  wire logic [15:0] word_in,      // offered word
  output logic      [15:0] instr_out,    // word to the core
  output logic             valid_out     // word present
);
  logic [7:0] mem [4096];
  logic [7:0] rd_q = 8'h00;
  logic       hit_q = 1'b0;

  // ****************************************
  // memory and fetch port
  // ****************************************
  // the byte stays one cycle past the answer cycle before the bus toggles, so a sample one cycle late still sees it
  always @(posedge clk_in) begin
    hit_q <= rd_in;
    rd_q <= rd_in ? mem[addr_in] : ~rd_q;
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
  assign rdata_out = hit_q ? rd_q : ~rd_q;
  assign valid_out = offer_in && fetch_req_in;
  assign instr_out = valid_out ? word_in : ~word_in;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the branch and bit-set execution slice
// assumes the partner model serves data memory and the fetch port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, instr_valid_in, fetch_req_out, mem_rd_out, mem_wr_out;
  logic        branch_taken_out, flush_out, instr_done_out, tk;
  logic [15:0] instr_in;
  logic [15:0] word = 16'h0;
  logic        offer = 1'b0;
  logic [3:0]  flg = 4'h0;
  logic [3:0]  f;
  logic [7:0]  mem_rdata_in, mem_wdata_out, off;
  logic [20:0] pc_out;
  logic [20:0] exp_pc = 21'h0;
  logic [11:0] mem_addr_out;
  logic [1:0]  phase_out;
  logic [31:0] rd;
  logic        er;
  int          n_errors = 0;
  int          n_checks = 0;
  int          n_taken = 0;
  logic [7:0]  opc [5] = '{8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
  int          fsel [5] = '{0, 1, 0, 2, 3};
  logic        pol [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0};

  bbs_exec u_dut (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .instr_in, .instr_valid_in, .neg_flag_in(flg[0]),
    .carry_flag_in(flg[1]), .ovf_flag_in(flg[2]), .zero_flag_in(flg[3]), .index_base_in(12'h200),
    .mem_rdata_in, .pc_out, .fetch_req_out, .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out,
    .branch_taken_out, .flush_out, .phase_out, .instr_done_out);
  bbs_mem_model u_mem (.clk_in, .addr_in(mem_addr_out), .rd_in(mem_rd_out), .wr_in(mem_wr_out),
    .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in), .fetch_req_in(fetch_req_out),
    .offer_in(offer), .word_in(word), .instr_out(instr_in), .valid_out(instr_valid_in));

  always #5 clk_in = ~clk_in;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, want);
      n_errors++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer, request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // no assumed latency: only the watchdog bounds this wait
    do begin
      @(posedge clk_in);
    end while (!pready_out);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask

  // offer one word, wait for the accept and the retire, then compare
  task automatic run(input logic [15:0] w, input int cyc);
    int n;
    offer <= 1'b1;
    word <= w;
    // the watchdog is the only limit on both waits
    do begin
      @(posedge clk_in);
    end while (!(instr_valid_in && fetch_req_out && !flush_out && phase_out == bbs_pkg::BBS_Q1));
    offer <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!instr_done_out);
    check(32'(n), 32'(cyc));
    check({11'h0, pc_out}, {11'h0, exp_pc});
  endtask

  task automatic bset(input logic a, input logic [7:0] fr, input logic [2:0] b,
                      input logic [11:0] ad, input logic [7:0] v);
    u_mem.mem[ad] = v;
    exp_pc = exp_pc + 21'h2;
    run({4'h8, b, a, fr}, 4);
    check({24'h0, u_mem.mem[ad]}, {24'h0, v | (8'h01 << b)});
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    // reset values, then the unmapped hole answers with an error
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0, rd, er);
      check(rd, rv[i]);
      check({31'h0, er}, {31'h0, i == 4});
    end
    exp_pc = exp_pc + 21'h2 + 21'h0007fe;
    run({5'h1a, 11'h3ff}, 8);
    // each condition both ways, with the offset extremes
    for (int i = 0; i < 5; i++) begin
      for (int v = 0; v < 2; v++) begin
        f = (v != 0) ? 4'h0 : 4'hf;
        f[fsel[i]] = v[0];
        flg <= f;
        tk = (v[0] == pol[i]);
        off = (v != 0) ? 8'h80 : 8'h7f;
        exp_pc = exp_pc + 21'h2 + (tk ? {{12{off[7]}}, off, 1'b0} : 21'h0);
        n_taken += tk;
        run({opc[i], off}, tk ? 8 : 4);
      end
    end
    exp_pc = exp_pc + 21'h2 + 21'h1ff800;
    run({5'h1a, 11'h400}, 8);
    apb(1'b1, 8'h04, 32'h5, rd, er);
    bset(1'b1, 8'h34, 3'd7, 12'h534, 8'h0a);
    bset(1'b0, 8'h20, 3'd0, 12'h020, 8'h80);
    bset(1'b0, 8'h80, 3'd3, 12'hf80, 8'h00);
    apb(1'b1, 8'h00, 32'h1, rd, er);
    bset(1'b0, 8'h10, 3'd2, 12'h210, 8'h01);
    bset(1'b0, 8'h5f, 3'd5, 12'h25f, 8'hff);
    bset(1'b0, 8'h60, 3'd1, 12'hf60, 8'h00);
    bset(1'b1, 8'h10, 3'd6, 12'h510, 8'h00);
    // a word outside this slice runs as a one-cycle nop
    exp_pc = exp_pc + 21'h2;
    run(16'h0000, 4);
    apb(1'b0, 8'h08, 32'h0, rd, er);
    check({24'h0, rd[15:8]}, 32'(n_taken + 2));
    tally_and_finish();
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
